// ===== hdl/aogfe_encoder.sv
// Antenna offset, geometric accuracy, altitude and collision-avoidance field encoder.
// Assumes installation data written over APB and sensor inputs synchronous to clk.
//
// Notes on behaviour
// - Lateral field is direction bit (1 right) plus 2-bit 2/4/6 m magnitude.
// - Lateral distance beyond 6 m saturates the magnitude to the 6 m code.
// - Lateral code 000 for no data, 100 for true zero offset.
// - Offsets round to nearest step, plus or minus one metre around nominal.
// - Longitudinal 0 means no data, 1 means sensor already compensates offset.
// - Longitudinal codes 2..31 are aft offset in metres halved plus one.
// - Longitudinal offset beyond 60 m saturates to the all-ones code.
// - Accuracy code 0 unknown/>150 m, 1 <=150 m, 2 45 m, never 3.
// - Geometric altitude passes as ellipsoid height to both message types.
// - Collision-avoidance flag and advisory come from the reply source.
// - With no collision-avoidance system both flag and advisory are zero.
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
module aogfe_encoder (
  // Clock and reset
  input  wire logic                            clk,
  input  wire logic                            rst_n,
  // APB slave
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [7:0]                      paddr,
  input  wire logic [31:0]                     pwdata,
  input  wire logic [3:0]                      pstrb,
  output logic      [31:0]                     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  // Sensor sources
  input  wire aogfe_pkg::aogfe_geo_s           geo_src,
  input  wire aogfe_pkg::aogfe_cas_s           cas_src,
  // Encoded fields to the message assembler
  output logic      [2:0]                      lat_field,
  output logic      [4:0]                      lon_field,
  output logic      [1:0]                      geometric_accuracy_code,
  output logic      [aogfe_pkg::ALT_W-1:0]     height_above_ellipsoid_air,
  output logic      [aogfe_pkg::ALT_W-1:0]     height_above_ellipsoid_surf,
  output logic                                 height_above_ellipsoid_valid,
  output logic                                 cas_operational,
  output logic      [aogfe_pkg::ADV_W-1:0]     resolution_advisory
);

  function automatic logic [2:0] enc_lat(aogfe_pkg::aogfe_lat_s c);
    logic [10:0] q;
    q = (11'({3'h0, c.dm}) + aogfe_pkg::HALF_DM) / aogfe_pkg::STEP_DM;
    if (!c.valid) begin
      enc_lat = aogfe_pkg::LAT_NODATA;
    end else if (q == 11'h000) begin
      enc_lat = aogfe_pkg::LAT_ZERO;
    end else if (q > 11'({9'h0, aogfe_pkg::LAT_MAG_MAX})) begin
      enc_lat = {c.right, aogfe_pkg::LAT_MAG_MAX};
    end else begin
      enc_lat = {c.right, q[1:0]};
    end
  endfunction

  function automatic logic [4:0] enc_lon(aogfe_pkg::aogfe_lon_s c);
    logic [10:0] q;
    q = (11'({1'h0, c.dm}) + aogfe_pkg::HALF_DM) / aogfe_pkg::STEP_DM;
    if (!c.valid) begin
      enc_lon = aogfe_pkg::LON_NODATA;
    end else if (c.comp) begin
      enc_lon = aogfe_pkg::LON_COMP;
    end else if (q >= 11'h01e) begin
      enc_lon = aogfe_pkg::LON_MAX;
    end else if (q == 11'h000) begin
      // Below one metre the formula would collide with the compensated code
      enc_lon = aogfe_pkg::LON_MIN;
    end else begin
      enc_lon = q[4:0] + 5'h01;
    end
  endfunction

  function automatic logic [1:0] enc_acc(aogfe_pkg::aogfe_geo_s g);
    if (!g.acc_valid) begin
      enc_acc = aogfe_pkg::ACC_UNK;
    end else if (g.acc_m <= aogfe_pkg::ACC_45_M) begin
      enc_acc = aogfe_pkg::ACC_45;
    end else if (g.acc_m <= aogfe_pkg::ACC_150_M) begin
      enc_acc = aogfe_pkg::ACC_150;
    end else begin
      enc_acc = aogfe_pkg::ACC_UNK;
    end
  endfunction

  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] wd, logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // Register bus state
  aogfe_pkg::aogfe_lat_s lat_cfg_q, lat_cfg_d;
  aogfe_pkg::aogfe_lon_s lon_cfg_q, lon_cfg_d;
  logic [31:0]           prdata_q, prdata_d;
  logic                  pready_q, pready_d;
  logic                  pslverr_q, pslverr_d;
  logic                  setup;
  logic                  wr_take;
  logic                  mapped;
  logic [31:0]           lat_word;
  logic [31:0]           lon_word;

  // Encoded field state
  logic [2:0]                  lat_q, lat_d;
  logic [4:0]                  lon_q, lon_d;
  logic [1:0]                  acc_q, acc_d;
  logic [aogfe_pkg::ALT_W-1:0] ellh_q, ellh_d;
  logic                        ellhv_q, ellhv_d;
  logic                        casop_q, casop_d;
  logic [aogfe_pkg::ADV_W-1:0] adv_q, adv_d;

  assign setup    = psel && !penable;
  assign wr_take  = psel && penable && pready_q && pwrite;
  assign mapped   = (paddr == aogfe_pkg::LAT_CFG_OFF) || (paddr == aogfe_pkg::LON_CFG_OFF) ||
                    (paddr == aogfe_pkg::FIELD_STS_OFF);
  assign lat_word = {22'h0, lat_cfg_q.valid, lat_cfg_q.right, lat_cfg_q.dm};
  assign lon_word = {20'h0, lon_cfg_q.valid, lon_cfg_q.comp, lon_cfg_q.dm};

  // Zero-wait slave: ready and read data are prepared in the setup cycle
  always_comb begin
    logic [31:0] m;
    m         = 32'h0;
    lat_cfg_d = lat_cfg_q;
    lon_cfg_d = lon_cfg_q;
    pready_d  = setup;
    pslverr_d = setup && (!mapped || (pwrite && paddr == aogfe_pkg::FIELD_STS_OFF));
    prdata_d  = prdata_q;
    if (setup) begin
      case (paddr)
        aogfe_pkg::LAT_CFG_OFF:   prdata_d = lat_word;
        aogfe_pkg::LON_CFG_OFF:   prdata_d = lon_word;
        aogfe_pkg::FIELD_STS_OFF: prdata_d = {21'h0, casop_q, acc_q, lon_q, lat_q};
        default:                  prdata_d = 32'h0;
      endcase
    end
    if (wr_take && paddr == aogfe_pkg::LAT_CFG_OFF) begin
      m         = merge(lat_word, pwdata, pstrb);
      lat_cfg_d = {m[aogfe_pkg::LAT_VALID_BIT], m[aogfe_pkg::LAT_RIGHT_BIT],
                   m[aogfe_pkg::LAT_DM_LSB +: 8]};
    end
    if (wr_take && paddr == aogfe_pkg::LON_CFG_OFF) begin
      m         = merge(lon_word, pwdata, pstrb);
      lon_cfg_d = {m[aogfe_pkg::LON_VALID_BIT], m[aogfe_pkg::LON_COMP_BIT],
                   m[aogfe_pkg::LON_DM_LSB +: 10]};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lat_cfg_q <= '0;
      lon_cfg_q <= '0;
      prdata_q  <= 32'h0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      lat_cfg_q <= lat_cfg_d;
      lon_cfg_q <= lon_cfg_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Field encoding
  always_comb begin
    lat_d   = enc_lat(lat_cfg_q);
    lon_d   = enc_lon(lon_cfg_q);
    acc_d   = enc_acc(geo_src);
    ellh_d  = geo_src.alt_valid ? geo_src.alt : '0;
    ellhv_d = geo_src.alt_valid;
    // Same source as the interrogation replies, so the two never disagree
    casop_d = cas_src.installed ? cas_src.operational : 1'b0;
    adv_d   = cas_src.installed ? cas_src.adv : '0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lat_q   <= aogfe_pkg::LAT_NODATA;
      lon_q   <= aogfe_pkg::LON_NODATA;
      acc_q   <= aogfe_pkg::ACC_UNK;
      ellh_q  <= '0;
      ellhv_q <= 1'b0;
      casop_q <= 1'b0;
      adv_q   <= '0;
    end else begin
      lat_q   <= lat_d;
      lon_q   <= lon_d;
      acc_q   <= acc_d;
      ellh_q  <= ellh_d;
      ellhv_q <= ellhv_d;
      casop_q <= casop_d;
      adv_q   <= adv_d;
    end
  end

  assign prdata                  = prdata_q;
  assign pready                  = pready_q;
  assign pslverr                 = pslverr_q;
  assign lat_field               = lat_q;
  assign lon_field               = lon_q;
  assign geometric_accuracy_code      = acc_q;
  assign height_above_ellipsoid_air   = ellh_q;
  assign height_above_ellipsoid_surf  = ellh_q;
  assign height_above_ellipsoid_valid = ellhv_q;
  assign cas_operational              = casop_q;
  assign resolution_advisory          = adv_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_lat_dir_bit: assert property (
    lat_cfg_q.valid && lat_cfg_q.dm >= 8'h0a |=> lat_field[2] == $past(lat_cfg_q.right))
    else $error("lateral direction bit wrong");
  chk_lat_saturate: assert property (
    lat_cfg_q.valid && lat_cfg_q.dm >= 8'h46 |=> lat_field[1:0] == 2'h3)
    else $error("lateral magnitude not saturated");
  chk_lat_special: assert property (
    (!lat_cfg_q.valid |=> lat_field == 3'h0) and
    (lat_cfg_q.valid && lat_cfg_q.dm < 8'h0a |=> lat_field == 3'h4))
    else $error("lateral no-data or zero code wrong");
  chk_lat_round: assert property (
    lat_cfg_q.valid && lat_cfg_q.dm >= 8'h0a && lat_cfg_q.dm < 8'h1e |=> lat_field[1:0] == 2'h1)
    else $error("lateral rounding wrong");
  chk_lon_special: assert property (
    !lon_cfg_q.valid || lon_cfg_q.comp |=> lon_field == ($past(lon_cfg_q.valid) ? 5'h01 : 5'h00))
    else $error("longitudinal special code wrong");
  chk_lon_formula: assert property (
    lon_cfg_q.valid && !lon_cfg_q.comp && lon_cfg_q.dm >= 10'h01e && lon_cfg_q.dm < 10'h032
    |=> lon_field == 5'h03)
    else $error("longitudinal formula wrong");
  chk_lon_saturate: assert property (
    lon_cfg_q.valid && !lon_cfg_q.comp && lon_cfg_q.dm > 10'h258 |=> lon_field == 5'h1f)
    else $error("longitudinal not saturated");
  chk_acc_range: assert property (
    geometric_accuracy_code != 2'h3 and
    (geo_src.acc_valid && geo_src.acc_m <= 16'h002d |=> geometric_accuracy_code == 2'h2))
    else $error("accuracy code wrong");
  chk_height_pass: assert property (
    geo_src.alt_valid |=> height_above_ellipsoid_air == $past(geo_src.alt) &&
    height_above_ellipsoid_surf == height_above_ellipsoid_air)
    else $error("ellipsoid height not passed");
  chk_cas_source: assert property (
    cas_src.installed |=> resolution_advisory == $past(cas_src.adv) &&
    cas_operational == $past(cas_src.operational))
    else $error("advisory not from reply source");
  chk_cas_absent: assert property (
    !cas_src.installed [*2] |-> cas_operational == 1'b0 && resolution_advisory == '0)
    else $error("absent system not zero");
  chk_apb_ready: assert property (
    setup |=> pready && psel && penable ##1 !pready)
    else $error("APB ready timing wrong");

  cov_lat_zero:   cover property (lat_field == 3'h4);
  cov_lon_max:    cover property (lon_field == 5'h1f);
  cov_cas_switch: cover property (cas_src.installed ##1 !cas_src.installed ##1 cas_operational == 1'b0);

endmodule // aogfe_encoder

// ===== hdl/aogfe_pkg.sv
// Package for the antenna offset / geometric accuracy field encoder.
// Assumes one 125 MHz clock and an APB register port with 32-bit data.
package aogfe_pkg;

  // Register byte offsets
  localparam logic [7:0] LAT_CFG_OFF   = 8'h00;
  localparam logic [7:0] LON_CFG_OFF   = 8'h04;
  localparam logic [7:0] FIELD_STS_OFF = 8'h08;

  // Lateral config fields
  localparam int LAT_DM_LSB    = 0;
  localparam int LAT_RIGHT_BIT = 8;
  localparam int LAT_VALID_BIT = 9;
  // Longitudinal config fields
  localparam int LON_DM_LSB    = 0;
  localparam int LON_COMP_BIT  = 10;
  localparam int LON_VALID_BIT = 11;
  // Status fields
  localparam int STS_LAT_LSB   = 0;
  localparam int STS_LON_LSB   = 3;
  localparam int STS_ACC_LSB   = 8;
  localparam int STS_CAS_BIT   = 10;

  // Offsets are given in decimetres; one coded step is 2 m = 20 dm
  localparam logic [10:0] STEP_DM     = 11'h014;
  localparam logic [10:0] HALF_DM     = 11'h00a;
  localparam logic [1:0]  LAT_MAG_MAX = 2'h3;
  localparam logic [2:0]  LAT_NODATA  = 3'h0;
  localparam logic [2:0]  LAT_ZERO    = 3'h4;
  localparam logic [4:0]  LON_NODATA  = 5'h00;
  localparam logic [4:0]  LON_COMP    = 5'h01;
  localparam logic [4:0]  LON_MIN     = 5'h02;
  localparam logic [4:0]  LON_MAX     = 5'h1f;

  // Accuracy thresholds in metres
  localparam logic [15:0] ACC_45_M  = 16'h002d;
  localparam logic [15:0] ACC_150_M = 16'h0096;
  localparam logic [1:0]  ACC_UNK   = 2'h0;
  localparam logic [1:0]  ACC_150   = 2'h1;
  localparam logic [1:0]  ACC_45    = 2'h2;

  localparam int ADV_W = 26;
  localparam int ALT_W = 16;

  typedef struct packed {
    logic       valid;
    logic       right;
    logic [7:0] dm;
  } aogfe_lat_s;

  typedef struct packed {
    logic       valid;
    logic       comp;
    logic [9:0] dm;
  } aogfe_lon_s;

  typedef struct packed {
    logic             alt_valid;
    logic [ALT_W-1:0] alt;
    logic             acc_valid;
    logic [15:0]      acc_m;
  } aogfe_geo_s;

  typedef struct packed {
    logic            installed;
    logic            operational;
    logic [ADV_W-1:0] adv;
  } aogfe_cas_s;

endpackage

// ===== verification/aogfe_src_model.sv
// Sensor-source model for the field encoder: altitude, accuracy and collision-avoidance data.
// Assumes the bench calls its tasks; every change lands just after a rising edge of clk.
`timescale 1ns/100ps
module aogfe_src_model (
  // Clock
  input  wire logic             clk,
  // Sources toward the encoder
  output aogfe_pkg::aogfe_geo_s geo,
  output aogfe_pkg::aogfe_cas_s cas
);
  initial begin
    geo = '0;
    cas = '0;
  end

  task automatic set_geo(input logic av, input logic [15:0] alt, input logic cv, input logic [15:0] acc);
    @(posedge clk);
    geo <= {av, alt, cv, acc};
  endtask

  // The same word feeds the interrogation replies, so the broadcast must match it
  task automatic set_cas(input logic inst, input logic op, input logic [25:0] adv);
    @(posedge clk);
    cas <= {inst, op, adv};
  endtask
endmodule // aogfe_src_model

// ===== verification/test_antenna_offset_gva_field_encoder.sv
// Self-checking bench for the field encoder: APB configuration, sensor inputs, encoded fields.
// Assumes zero-wait APB answers are not relied on; every wait is bounded.
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module test_antenna_offset_gva_field_encoder;
  logic                  clk, rst_n, psel, penable, pwrite, pready, pslverr, height_above_ellipsoid_valid;
  logic                  cas_operational;
  logic [7:0]            paddr;
  logic [31:0]           pwdata, prdata, rd;
  logic [3:0]            pstrb;
  logic [2:0]            lat_field;
  logic [4:0]            lon_field;
  logic [1:0]            geometric_accuracy_code;
  logic [15:0]           height_above_ellipsoid_air, height_above_ellipsoid_surf;
  logic [25:0]           resolution_advisory;
  logic                  er;
  aogfe_pkg::aogfe_geo_s geo_src;
  aogfe_pkg::aogfe_cas_s cas_src;
  int                    error_cnt = 0;
  int                    num_checks = 0;

  aogfe_encoder dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .geo_src(geo_src),
    .cas_src(cas_src), .lat_field(lat_field), .lon_field(lon_field),
    .geometric_accuracy_code(geometric_accuracy_code), .height_above_ellipsoid_air(height_above_ellipsoid_air),
    .height_above_ellipsoid_surf(height_above_ellipsoid_surf),
    .height_above_ellipsoid_valid(height_above_ellipsoid_valid), .cas_operational(cas_operational),
    .resolution_advisory(resolution_advisory));
  aogfe_src_model m (.clk(clk), .geo(geo_src), .cas(cas_src));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic finish_test;
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    // Look just after each edge, so the answer is taken in the cycle it stands
    #1;
    while (pready !== 1'b1 && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 50) begin
      error_cnt++;
      $display("ERROR t=%0t no bus answer", $time);
    end
    rd = prdata;
    er = pslverr;
    @(posedge clk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Register as the write ends, field one edge after it, two spare
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic lat(input logic [9:0] cfg, input logic [2:0] exp);
    apb(1'b1, aogfe_pkg::LAT_CFG_OFF, {22'h0, cfg});
    settle;
    `CHK(lat_field, exp)
  endtask

  task automatic lon(input logic [11:0] cfg, input logic [4:0] exp);
    apb(1'b1, aogfe_pkg::LON_CFG_OFF, {20'h0, cfg});
    settle;
    `CHK(lon_field, exp)
  endtask

  task automatic geo(input logic av, input logic [15:0] alt, input logic cv, input logic [15:0] acc,
                     input logic [1:0] exp);
    m.set_geo(av, alt, cv, acc);
    settle;
    `CHK(geometric_accuracy_code, exp)
    `CHK(height_above_ellipsoid_air, (av ? alt : 16'h0000))
    `CHK(height_above_ellipsoid_surf, (av ? alt : 16'h0000))
    `CHK(height_above_ellipsoid_valid, av)
  endtask

  task automatic cas(input logic inst, input logic op, input logic [25:0] adv);
    m.set_cas(inst, op, adv);
    settle;
    `CHK(cas_operational, (inst & op))
    `CHK(resolution_advisory, (inst ? adv : 26'h0000000))
  endtask

  initial begin
    #200000;
    error_cnt++;
    $display("ERROR t=%0t watchdog expired", $time);
    finish_test;
  end

  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hf;
    repeat (5) @(posedge clk);
    #1;
    `CHK({lat_field, lon_field, geometric_accuracy_code, cas_operational}, 11'h000)
    @(posedge clk);
    rst_n <= 1'b1;
    lat({2'b00, 8'd40}, 3'h0);
    lat({2'b10, 8'd9}, 3'h4);
    lat({2'b11, 8'd10}, 3'h5);
    lat({2'b10, 8'd29}, 3'h1);
    lat({2'b10, 8'd30}, 3'h2);
    lat({2'b11, 8'd69}, 3'h7);
    lat({2'b10, 8'd70}, 3'h3);
    $display("test lateral done");
    lon({2'b00, 10'd100}, 5'h00);
    lon({2'b11, 10'd300}, 5'h01);
    lon({2'b10, 10'd9}, 5'h02);
    lon({2'b10, 10'd40}, 5'h03);
    lon({2'b10, 10'd570}, 5'h1e);
    lon({2'b10, 10'd590}, 5'h1f);
    lon({2'b10, 10'd1023}, 5'h1f);
    $display("test longitudinal done");
    geo(1'b0, 16'h1234, 1'b0, 16'h0005, 2'h0);
    geo(1'b1, 16'habcd, 1'b1, 16'h002d, 2'h2);
    geo(1'b1, 16'h8001, 1'b1, 16'h002e, 2'h1);
    geo(1'b1, 16'h0000, 1'b1, 16'h0096, 2'h1);
    geo(1'b1, 16'hffff, 1'b1, 16'h0097, 2'h0);
    geo(1'b1, 16'h0001, 1'b1, 16'hffff, 2'h0);
    $display("test altitude done");
    cas(1'b1, 1'b1, 26'h2aaaaaa);
    cas(1'b0, 1'b1, 26'h3ffffff);
    cas(1'b1, 1'b0, 26'h1555555);
    $display("test collision avoidance done");
    apb(1'b1, aogfe_pkg::LAT_CFG_OFF, 32'hffffffff);
    apb(1'b0, aogfe_pkg::LAT_CFG_OFF, 32'h0);
    `CHK({er, rd}, 33'h0000003ff)
    settle;
    apb(1'b0, aogfe_pkg::FIELD_STS_OFF, 32'h0);
    `CHK({er, rd}, 33'h0000000ff)
    apb(1'b1, aogfe_pkg::FIELD_STS_OFF, 32'hffffffff);
    `CHK(er, 1'b1)
    apb(1'b0, 8'h0c, 32'h0);
    `CHK({er, rd}, 33'h100000000)
    $display("test registers done");
    @(posedge clk);
    rst_n <= 1'b0;
    #2;
    `CHK({lat_field, lon_field, cas_operational}, 9'h000)
    finish_test;
  end
endmodule // test_antenna_offset_gva_field_encoder
